// file: qenc_decoder.sv
/*
 Input synchroniser and phase decoder for the encoder interface.
 Assumes encoder pins are asynchronous and the configuration is static while enabled.
*/
`timescale 1ns/100ps
module qenc_decoder
    import qenc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic index_input,
    input wire logic enable,
    input wire logic swap,
    input wire logic signal_mode_select,
    input wire logic capture_mode_select,
    input wire logic invert_phase_a,
    input wire logic invert_phase_b,
    input wire logic invert_index,
    qenc_edge_if.src ev
);
    logic [2:0] sync1_ff, sync2_ff, prev_ff;
    logic dir_ff;
    // one edge per clock is resolved, so quarter-rate inputs are safe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= {index_input, phase_b_input, phase_a_input};
            sync2_ff <= sync1_ff;
        end
    end
    wire a_inv = sync2_ff[0] ^ invert_phase_a;
    wire b_inv = sync2_ff[1] ^ invert_phase_b;
    wire i_cur = sync2_ff[2] ^ invert_index;
    wire a_cur = swap ? b_inv : a_inv;
    wire b_cur = swap ? a_inv : b_inv;
    wire edge_a = a_cur ^ prev_ff[0];
    wire edge_b = b_cur ^ prev_ff[1];
    wire is_quad = qenc_signal_mode_select_t'(signal_mode_select) == qenc_sig_quadrature;
    wire quad_err = is_quad & edge_a & edge_b;
    wire quad_step = ~quad_err & (edge_a | (capture_mode_select & edge_b));
    wire quad_up = edge_a ? (a_cur ^ b_cur) : ~(a_cur ^ b_cur);
    wire cd_step = edge_a & a_cur;
    wire step = enable & (is_quad ? quad_step : cd_step);
    wire up = is_quad ? quad_up : b_cur;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= 3'h0;
            dir_ff <= 1'b1;
            ev.step <= 1'b0;
            ev.up <= 1'b0;
            ev.direction <= 1'b1;
            ev.dir_chg <= 1'b0;
            ev.phase_err <= 1'b0;
            ev.index_rise <= 1'b0;
        end else begin
            prev_ff <= {i_cur, b_cur, a_cur};
            dir_ff <= step ? up : dir_ff;
            ev.step <= step;
            ev.up <= up;
            ev.direction <= step ? up : dir_ff;
            ev.dir_chg <= step & (up != dir_ff);
            ev.phase_err <= enable & quad_err;
            ev.index_rise <= enable & i_cur & ~prev_ff[2];
        end
    end
    chk_phase_error: assert property (@(posedge pclk) disable iff (!presetn)
        (enable && is_quad && edge_a && edge_b) |=> (ev.phase_err && !ev.step))
        else $error("simultaneous phase change not flagged");
    chk_quad_forward: assert property (@(posedge pclk) disable iff (!presetn)
        (enable && is_quad && edge_a && !edge_b && (a_cur != b_cur)) |=> (ev.step && ev.up))
        else $error("phase A leading did not count up");
    chk_capture_a_only: assert property (@(posedge pclk) disable iff (!presetn)
        (is_quad && !capture_mode_select && !edge_a) |=> !ev.step)
        else $error("phase B edge counted in A-only mode");
    cov_dir_change: cover property (@(posedge pclk) disable iff (!presetn) ev.dir_chg);
endmodule : qenc_decoder

// file: qenc_edge_if.sv
/*
 Decoded edge events passed from the decoder to the counters.
 Assumes all signals are registered in the pclk domain.
*/
`timescale 1ns/100ps
interface qenc_edge_if;
    logic step;
    logic up;
    logic direction;
    logic dir_chg;
    logic phase_err;
    logic index_rise;
    modport src (output step, up, direction, dir_chg, phase_err, index_rise);
    modport dst (input step, up, direction, dir_chg, phase_err, index_rise);
endinterface : qenc_edge_if

// file: qenc_enc_model.sv
/*
 Behavioural incremental encoder driving the phase and index pins of the encoder interface.
 Assumes a running pclk; every pin change is followed by six quiet cycles.
*/
`timescale 1ns/100ps
module qenc_enc_model (
    input wire logic pclk,
    output logic pa,
    output logic pb,
    output logic index_pin
);
    logic [1:0] ph;

    initial begin
        pa = 1'b0;
        pb = 1'b0;
        index_pin = 1'b0;
        ph = 2'h0;
    end

    // {a,b} walks 00,10,11,01 forward, so a leads b
    function automatic logic [1:0] gray(input logic [1:0] p);
        return {p[1] ^ p[0], p[1]};
    endfunction : gray

    task automatic hold();
        repeat (6) @(posedge pclk);
    endtask : hold

    task automatic quad(input logic fwd);
        @(posedge pclk);
        ph = fwd ? ph + 2'h1 : ph - 2'h1;
        {pa, pb} <= gray(ph);
        hold();
    endtask : quad

    // half a cycle jump flips both phases in one cycle
    task automatic clash();
        @(posedge pclk);
        ph = ph + 2'h2;
        {pa, pb} <= gray(ph);
        hold();
    endtask : clash

    task automatic cd_step(input logic up);
        @(posedge pclk);
        pb <= up;
        hold();
        pa <= 1'b1;
        hold();
        pa <= 1'b0;
        hold();
    endtask : cd_step

    task automatic park();
        @(posedge pclk);
        ph = 2'h0;
        {pa, pb} <= 2'h0;
        hold();
    endtask : park

    task automatic index_pulse();
        @(posedge pclk);
        index_pin <= 1'b1;
        hold();
        index_pin <= 1'b0;
        hold();
    endtask : index_pulse
endmodule : qenc_enc_model

// file: qenc_pkg.sv
/*
 Types shared by the encoder interface modules.
 Assumes qenc_regs.svh supplies the numeric constants.
*/
package qenc_pkg;
    typedef enum logic {qenc_sig_quadrature, qenc_sig_clock_dir} qenc_signal_mode_select_t;
    typedef logic [7:0] qenc_addr_t;
endpackage : qenc_pkg

// file: qenc_regs.svh
/*
 Register offsets, field positions and reset values of the encoder interface.
 Assumes byte addresses on an 8-bit APB address, one aligned 32-bit word per register.
*/
`ifndef QENC_REGS_SVH
`define QENC_REGS_SVH
`define QENC_OFF_CTRL 8'h00
`define QENC_OFF_STATUS 8'h04
`define QENC_OFF_POSITION 8'h08
`define QENC_OFF_MAXPOS 8'h0C
`define QENC_OFF_LOAD 8'h10
`define QENC_OFF_TIMER 8'h14
`define QENC_OFF_ACCUM 8'h18
`define QENC_OFF_SPEED 8'h1C
`define QENC_OFF_INTMASK 8'h20
`define QENC_OFF_RAWSTAT 8'h24
`define QENC_OFF_INTCLR 8'h28
`define QENC_CTRL_EN 0
`define QENC_CTRL_SWAP 1
`define QENC_CTRL_SIG_MODE 2
`define QENC_CTRL_CAP_MODE 3
`define QENC_CTRL_RES_MODE 4
`define QENC_CTRL_VELEN 5
`define QENC_CTRL_VEL_DIV_LO 6
`define QENC_CTRL_VEL_DIV_HI 8
`define QENC_CTRL_INV_A 9
`define QENC_CTRL_INV_B 10
`define QENC_CTRL_INV_I 11
`define QENC_CTRL_W 12
`define QENC_INT_INDEX 0
`define QENC_INT_TIMER 1
`define QENC_INT_DIR 2
`define QENC_INT_ERR 3
`define QENC_INT_W 4
`define QENC_RST_CTRL 12'h000
`define QENC_RST_WORD 32'h00000000
`endif

// file: qenc_top.sv
/*
 Encoder interface top: APB register slave, position integrator and event status.
 Assumes an APB master in the pclk domain and static configuration while enabled.
*/
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "qenc_regs.svh"
module qenc_top
    import qenc_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int VEL_W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic index_input,
    output logic irq
);
    logic [`QENC_CTRL_W-1:0] ctrl_ff;
    logic [POS_W-1:0] pos_ff, maxpos_ff;
    logic [VEL_W-1:0] load_ff;
    logic [`QENC_INT_W-1:0] mask_ff, raw_ff;
    logic index_seen_ff, irq_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;
    logic [VEL_W-1:0] timer_w, accum_w, speed_w;
    logic expire_w;

    qenc_edge_if ev ();

    wire pos_en = ctrl_ff[`QENC_CTRL_EN];
    wire reset_mode = ctrl_ff[`QENC_CTRL_RES_MODE];
    wire vel_en = ctrl_ff[`QENC_CTRL_VELEN] & pos_en;

    qenc_decoder u_decoder (
        .pclk(pclk),
        .presetn(presetn),
        .phase_a_input(phase_a_input),
        .phase_b_input(phase_b_input),
        .index_input(index_input),
        .enable(pos_en),
        .swap(ctrl_ff[`QENC_CTRL_SWAP]),
        .signal_mode_select(ctrl_ff[`QENC_CTRL_SIG_MODE]),
        .capture_mode_select(ctrl_ff[`QENC_CTRL_CAP_MODE]),
        .invert_phase_a(ctrl_ff[`QENC_CTRL_INV_A]),
        .invert_phase_b(ctrl_ff[`QENC_CTRL_INV_B]),
        .invert_index(ctrl_ff[`QENC_CTRL_INV_I]),
        .ev(ev.src)
    );

    // shares the decoder output, so mode, swap and capture settings match
    qenc_velocity #(.VEL_W(VEL_W)) u_velocity (
        .pclk(pclk),
        .presetn(presetn),
        .enable(vel_en),
        .velocity_divider(ctrl_ff[`QENC_CTRL_VEL_DIV_HI:`QENC_CTRL_VEL_DIV_LO]),
        .load(load_ff),
        .ev(ev.dst),
        .timer_ff(timer_w),
        .accum_ff(accum_w),
        .speed_ff(speed_w),
        .expire_ff(expire_w)
    );

    // apb: one wait state, so read data and pready both come from flops
    wire access = psel & penable;
    wire first_access = access & ~pready_ff;
    wire wr_en = access & pready_ff & pwrite & ~pslverr_ff;
    wire sel_ctrl = paddr == `QENC_OFF_CTRL;
    wire sel_status = paddr == `QENC_OFF_STATUS;
    wire sel_pos = paddr == `QENC_OFF_POSITION;
    wire sel_max = paddr == `QENC_OFF_MAXPOS;
    wire sel_load = paddr == `QENC_OFF_LOAD;
    wire sel_timer = paddr == `QENC_OFF_TIMER;
    wire sel_accum = paddr == `QENC_OFF_ACCUM;
    wire sel_speed = paddr == `QENC_OFF_SPEED;
    wire sel_mask = paddr == `QENC_OFF_INTMASK;
    wire sel_raw = paddr == `QENC_OFF_RAWSTAT;
    wire sel_clr = paddr == `QENC_OFF_INTCLR;
    wire mapped = sel_ctrl | sel_status | sel_pos | sel_max | sel_load | sel_timer |
                  sel_accum | sel_speed | sel_mask | sel_raw | sel_clr;
    wire wr_ctrl = wr_en & sel_ctrl;
    wire wr_pos = wr_en & sel_pos;
    wire wr_max = wr_en & sel_max;
    wire wr_load = wr_en & sel_load;
    wire wr_mask = wr_en & sel_mask;
    wire wr_clr = wr_en & sel_clr;

    wire [31:0] status_word = {29'h0, index_seen_ff, raw_ff[`QENC_INT_ERR], ev.direction};
    wire [31:0] rd_data =
        sel_ctrl ? {{(32-`QENC_CTRL_W){1'b0}}, ctrl_ff} :
        sel_status ? status_word :
        sel_pos ? 32'(pos_ff) :
        sel_max ? 32'(maxpos_ff) :
        sel_load ? 32'(load_ff) :
        sel_timer ? 32'(timer_w) :
        sel_accum ? 32'(accum_w) :
        sel_speed ? 32'(speed_w) :
        sel_mask ? {{(32-`QENC_INT_W){1'b0}}, mask_ff} :
        sel_raw ? {{(32-`QENC_INT_W){1'b0}}, raw_ff} :
        sel_clr ? {{(32-`QENC_INT_W){1'b0}}, raw_ff & mask_ff} :
        32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= `QENC_RST_WORD;
        end else begin
            pready_ff <= first_access;
            pslverr_ff <= first_access & ~mapped;
            prdata_ff <= first_access ? rd_data : prdata_ff;
        end
    end

    // position integrator
    wire idx_reset = pos_en & reset_mode & ev.index_rise;
    wire at_max = pos_ff == maxpos_ff;
    wire at_zero = pos_ff == '0;
    wire [POS_W-1:0] pos_up = at_max ? '0 : pos_ff + 1'b1;
    wire [POS_W-1:0] pos_dn = at_zero ? maxpos_ff : pos_ff - 1'b1;
    wire [POS_W-1:0] pos_step = ev.up ? pos_up : pos_dn;
    wire [POS_W-1:0] nxt_pos = wr_pos ? POS_W'(pwdata) :
                               idx_reset ? '0 :
                               ev.step ? pos_step : pos_ff;
    wire nxt_index_seen = pos_en & (index_seen_ff | idx_reset);

    // events: a set in the clearing cycle survives the clear
    wire [`QENC_INT_W-1:0] events = {ev.phase_err, ev.dir_chg, expire_w, ev.index_rise};
    wire [`QENC_INT_W-1:0] clr_bits = wr_clr ? pwdata[`QENC_INT_W-1:0] : '0;
    wire [`QENC_INT_W-1:0] nxt_raw = (raw_ff & ~clr_bits) | events;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `QENC_RST_CTRL;
            pos_ff <= '0;
            maxpos_ff <= '0;
            load_ff <= '0;
            mask_ff <= '0;
            raw_ff <= '0;
            index_seen_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            ctrl_ff <= wr_ctrl ? pwdata[`QENC_CTRL_W-1:0] : ctrl_ff;
            pos_ff <= nxt_pos;
            maxpos_ff <= wr_max ? POS_W'(pwdata) : maxpos_ff;
            load_ff <= wr_load ? VEL_W'(pwdata) : load_ff;
            mask_ff <= wr_mask ? pwdata[`QENC_INT_W-1:0] : mask_ff;
            raw_ff <= nxt_raw;
            index_seen_ff <= nxt_index_seen;
            irq_ff <= |(raw_ff & mask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;

    chk_index_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (idx_reset && !wr_pos) |=> (pos_ff == '0 && index_seen_ff))
        else $error("index did not clear position");
    chk_index_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (ev.index_rise && !reset_mode && !ev.step && !wr_pos) |=> $stable(pos_ff))
        else $error("index moved position in max-wrap mode");
    chk_wrap_down: assert property (@(posedge pclk) disable iff (!presetn)
        (ev.step && !ev.up && at_zero && !idx_reset && !wr_pos) |=> (pos_ff == $past(maxpos_ff)))
        else $error("backward step from zero did not wrap");
    chk_wrap_up: assert property (@(posedge pclk) disable iff (!presetn)
        (ev.step && ev.up && at_max && !idx_reset && !wr_pos) |=> (pos_ff == '0))
        else $error("forward step at maximum did not wrap");
    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (events != '0) |=> ((raw_ff & $past(events)) == $past(events)))
        else $error("event not latched in raw status");
    chk_vel_gated: assert property (@(posedge pclk) disable iff (!presetn)
        (!pos_en) [*2] |-> (accum_w == '0 && !expire_w))
        else $error("velocity ran with integrator disabled");
    chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        first_access |=> (pready_ff ##1 !pready_ff))
        else $error("apb answer not after one wait state");
    chk_seen_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !pos_en |=> !index_seen_ff)
        else $error("index seen survived disable");
    cov_index_abs: cover property (@(posedge pclk) disable iff (!presetn) idx_reset ##[1:50] ev.step);
    cov_irq: cover property (@(posedge pclk) disable iff (!presetn) irq_ff ##[1:20] wr_clr);
endmodule : qenc_top

// file: qenc_top_test.sv
/*
 Self-checking bench of the encoder interface: APB master tasks, encoder model, expectations.
 Assumes the register map of qenc_regs.svh and an answering APB slave.
*/
`timescale 1ns/100ps
`include "qenc_regs.svh"
module qenc_top_test
    import qenc_pkg::*;
;
    localparam logic [31:0] EN = 32'h1 << `QENC_CTRL_EN;
    localparam logic [31:0] SWAP = 32'h1 << `QENC_CTRL_SWAP;
    localparam logic [31:0] SIG = 32'h1 << `QENC_CTRL_SIG_MODE;
    localparam logic [31:0] CAP = 32'h1 << `QENC_CTRL_CAP_MODE;
    localparam logic [31:0] RES = 32'h1 << `QENC_CTRL_RES_MODE;
    localparam logic [31:0] VEL = 32'h1 << `QENC_CTRL_VELEN;
    localparam logic [31:0] INV_A = 32'h1 << `QENC_CTRL_INV_A;
    localparam logic [31:0] INV_B = 32'h1 << `QENC_CTRL_INV_B;
    localparam logic [31:0] INV_I = 32'h1 << `QENC_CTRL_INV_I;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, pa, pb, index_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int err_total, check_count;

    qenc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_a_input(pa), .phase_b_input(pb), .index_input(index_pin), .irq(irq));
    qenc_enc_model enc_u (.pclk(pclk), .pa(pa), .pb(pb), .index_pin(index_pin));

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_total = 0;
        check_count = 0;
    end
    always #20 pclk = ~pclk;

    function automatic logic [31:0] wrap(input int p, input int m);
        return 32'((p % (m + 1) + m + 1) % (m + 1));
    endfunction : wrap
    // each of swap, invert a, invert b reverses the counting sense
    function automatic logic [31:0] turned(input int steps, input logic [2:0] m, input int top);
        return (^m) ? wrap(-steps, top) : wrap(steps, top);
    endfunction : turned
    function automatic logic [31:0] vel_count(input int edges, input int div);
        return 32'(edges >> div);
    endfunction : vel_count

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // pready and read data are taken at the rising edge that ends the access
    task automatic apb(input logic wr, input qenc_addr_t a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // read before the slave's flops update, so this is the value at the edge
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input qenc_addr_t a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input qenc_addr_t a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask : rd

    initial begin
        #(40 * 20000);
        err_total++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] q;
        logic e;
        int n;
        int k;
        int mx;
        int dv;
        void'($urandom(32'h264e));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            // reads carry random write data, which the slave must ignore
            apb(1'b0, qenc_addr_t'(i * 4), $urandom, q, e);
            check("reset value", q, (i == 1) ? 32'h1 : 32'h0);
            check("mapped error", {31'h0, e}, 32'h0);
        end
        apb(1'b1, qenc_addr_t'(8'h2C + 4 * $urandom_range(52, 0)), $urandom, q, e);
        check("unmapped write error", {31'h0, e}, 32'h1);
        apb(1'b0, qenc_addr_t'(8'h2C + 4 * $urandom_range(52, 0)), $urandom, q, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("unmapped data", q, 32'h0);
        mx = $urandom_range(12, 5);
        wr(`QENC_OFF_MAXPOS, 32'(mx));
        wr(`QENC_OFF_CTRL, EN | CAP);
        n = $urandom_range(20, 9);
        repeat (n) enc_u.quad(1'b1);
        rd(`QENC_OFF_POSITION, q);
        check("position up", q, wrap(n, mx));
        wr(`QENC_OFF_POSITION, 32'h0);
        enc_u.quad(1'b0);
        rd(`QENC_OFF_POSITION, q);
        check("wrap down", q, 32'(mx));
        rd(`QENC_OFF_RAWSTAT, q);
        check("direction event", {31'h0, q[`QENC_INT_DIR]}, 32'h1);
        rd(`QENC_OFF_STATUS, q);
        check("direction", {31'h0, q[0]}, 32'h0);
        wr(`QENC_OFF_CTRL, EN);
        wr(`QENC_OFF_POSITION, 32'h0);
        repeat (4) enc_u.quad(1'b1);
        rd(`QENC_OFF_POSITION, q);
        check("phase a only", q, 32'h2);
        for (int m = 0; m < 8; m++) begin
            wr(`QENC_OFF_CTRL, EN | CAP | (m[0] ? SWAP : 32'h0) | (m[1] ? INV_A : 32'h0) | (m[2] ? INV_B : 32'h0));
            repeat (10) @(posedge pclk);
            wr(`QENC_OFF_POSITION, 32'h0);
            repeat (3) enc_u.quad(1'b1);
            rd(`QENC_OFF_POSITION, q);
            check("swap invert", q, turned(3, m[2:0], mx));
        end
        wr(`QENC_OFF_CTRL, 32'h0);
        wr(`QENC_OFF_CTRL, EN | CAP | RES);
        wr(`QENC_OFF_POSITION, 32'h0);
        wr(`QENC_OFF_INTCLR, 32'hF);
        rd(`QENC_OFF_STATUS, q);
        check("index unseen", {31'h0, q[2]}, 32'h0);
        repeat (3) enc_u.quad(1'b1);
        enc_u.index_pulse();
        rd(`QENC_OFF_POSITION, q);
        check("index reset", q, 32'h0);
        rd(`QENC_OFF_STATUS, q);
        check("index seen", {31'h0, q[2]}, 32'h1);
        rd(`QENC_OFF_RAWSTAT, q);
        check("index event", {31'h0, q[`QENC_INT_INDEX]}, 32'h1);
        // inverting the idle-low index pin looks like a rising index edge
        repeat (2) enc_u.quad(1'b1);
        wr(`QENC_OFF_INTCLR, 32'hF);
        wr(`QENC_OFF_CTRL, EN | CAP | RES | INV_I);
        repeat (10) @(posedge pclk);
        rd(`QENC_OFF_RAWSTAT, q);
        check("inverted index event", {31'h0, q[`QENC_INT_INDEX]}, 32'h1);
        rd(`QENC_OFF_POSITION, q);
        check("inverted index reset", q, 32'h0);
        wr(`QENC_OFF_CTRL, EN | CAP);
        wr(`QENC_OFF_POSITION, 32'h0);
        repeat (2) enc_u.quad(1'b1);
        enc_u.index_pulse();
        rd(`QENC_OFF_POSITION, q);
        check("index ignored", q, 32'h2);
        wr(`QENC_OFF_INTCLR, 32'hF);
        wr(`QENC_OFF_INTMASK, 32'h1 << `QENC_INT_ERR);
        enc_u.clash();
        rd(`QENC_OFF_RAWSTAT, q);
        check("phase error", {31'h0, q[`QENC_INT_ERR]}, 32'h1);
        rd(`QENC_OFF_POSITION, q);
        check("no step on error", q, 32'h2);
        rd(`QENC_OFF_INTCLR, q);
        check("masked status", q, 32'h8);
        @(negedge pclk);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(`QENC_OFF_INTCLR, 32'h8);
        repeat (3) @(negedge pclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wr(`QENC_OFF_INTMASK, 32'h0);
        enc_u.clash();
        @(negedge pclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(`QENC_OFF_CTRL, EN | SIG);
        enc_u.park();
        wr(`QENC_OFF_POSITION, 32'h0);
        n = $urandom_range(6, 3);
        k = $urandom_range(2, 0);
        repeat (n) enc_u.cd_step(1'b1);
        repeat (k) enc_u.cd_step(1'b0);
        rd(`QENC_OFF_POSITION, q);
        check("clock direction", q, wrap(n - k, mx));
        wr(`QENC_OFF_CTRL, CAP | VEL);
        enc_u.park();
        repeat (4) enc_u.quad(1'b1);
        rd(`QENC_OFF_ACCUM, q);
        check("velocity needs enable", q, 32'h0);
        // long enough that the accumulator is read before the first expiry
        wr(`QENC_OFF_LOAD, 32'($urandom_range(480, 330)));
        for (int j = 0; j < 3; j++) begin
            dv = (j < 2) ? j : int'($urandom_range(7, 2));
            // dropping the velocity enable clears predivider and accumulator and reloads the timer from load
            wr(`QENC_OFF_CTRL, EN | CAP);
            wr(`QENC_OFF_CTRL, EN | CAP | VEL | (32'(dv) << `QENC_CTRL_VEL_DIV_LO));
            wr(`QENC_OFF_INTCLR, 32'hF);
            k = $urandom_range(40, 8);
            repeat (k) enc_u.quad(1'b1);
            rd(`QENC_OFF_ACCUM, q);
            check("accumulated", q, vel_count(k, dv));
            n = 0;
            do begin
                rd(`QENC_OFF_RAWSTAT, q);
                n++;
            end while (q[`QENC_INT_TIMER] !== 1'b1 && n < 150);
            check("timer expired", {31'h0, q[`QENC_INT_TIMER]}, 32'h1);
            rd(`QENC_OFF_SPEED, q);
            check("speed result", q, vel_count(k, dv));
            rd(`QENC_OFF_ACCUM, q);
            check("accumulator restart", q, 32'h0);
        end
        tally_and_finish();
    end
endmodule : qenc_top_test

// file: qenc_velocity.sv
/*
 Velocity predivider, period timer, edge accumulator and speed result.
 Assumes step pulses are one cycle wide and load is held by software.
*/
`timescale 1ns/100ps
module qenc_velocity
    import qenc_pkg::*;
#(
    parameter int VEL_W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic [2:0] velocity_divider,
    input wire logic [VEL_W-1:0] load,
    qenc_edge_if.dst ev,
    output logic [VEL_W-1:0] timer_ff,
    output logic [VEL_W-1:0] accum_ff,
    output logic [VEL_W-1:0] speed_ff,
    output logic expire_ff
);
    logic [6:0] pre_ff;
    wire [6:0] div_mask = 7'((8'h01 << velocity_divider) - 8'h01);
    wire pulse = ev.step && ((pre_ff & div_mask) == div_mask);
    wire [VEL_W-1:0] pulse_w = {{(VEL_W-1){1'b0}}, pulse};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= 7'h00;
            timer_ff <= '0;
            accum_ff <= '0;
            speed_ff <= '0;
            expire_ff <= 1'b0;
        end else if (!enable) begin
            pre_ff <= 7'h00;
            timer_ff <= load;
            accum_ff <= '0;
            expire_ff <= 1'b0;
        end else begin
            pre_ff <= ev.step ? pre_ff + 7'h01 : pre_ff;
            expire_ff <= timer_ff == '0;
            if (timer_ff == '0) begin
                timer_ff <= load;
                speed_ff <= accum_ff;
                accum_ff <= pulse_w;
            end else begin
                timer_ff <= timer_ff - 1'b1;
                accum_ff <= accum_ff + pulse_w;
            end
        end
    end
    chk_period_end: assert property (@(posedge pclk) disable iff (!presetn)
        (enable && timer_ff == '0) |=> (speed_ff == $past(accum_ff) && accum_ff <= 1 && timer_ff == $past(load)))
        else $error("period end did not move count to speed");
    chk_timer_down: assert property (@(posedge pclk) disable iff (!presetn)
        (enable && timer_ff != '0) |=> (timer_ff == $past(timer_ff) - 1 && !expire_ff))
        else $error("timer did not count down");
    cov_expire: cover property (@(posedge pclk) disable iff (!presetn) expire_ff && speed_ff != '0);
endmodule : qenc_velocity
